// file: pbd_pkg.sv
package pbd_pkg;
    // Queue and timer geometry
    localparam int PBD_DATA_W = 32;
    localparam int PBD_DEPTH = 16;
    localparam int PBD_TICK_W = 24;
    localparam int PBD_CNT_W = 5;
    localparam int PBD_ADDR_W = 12;

    // Register offsets
    localparam logic [11:0] OFF_HOST_CODE = 12'h000;
    localparam logic [11:0] OFF_QUEUE_READ = 12'h100;
    localparam logic [11:0] OFF_CONFIG = 12'h104;
    localparam logic [11:0] OFF_STATUS = 12'h108;
    localparam logic [11:0] OFF_COUNT = 12'h10C;
    localparam logic [11:0] OFF_ACTIVATE = 12'h330;

    // Field positions
    localparam int CFG_THR_LSB = 6;
    localparam int CFG_RUN_BIT = 5;
    localparam int CFG_TB_LSB = 3;
    localparam int CFG_CLR_BIT = 2;
    localparam int CFG_FLUSH_BIT = 1;
    localparam int ST_OVR_BIT = 1;
    localparam int ST_NE_BIT = 0;
    localparam int ACT_BIT = 0;
    localparam int CODE_W = 8;

    // Reset values
    localparam logic [1:0] THR_RESET = 2'h0;
    localparam logic [1:0] TB_RESET = 2'h0;
    localparam logic RUN_RESET = 1'b0;
    localparam logic ACT_RESET = 1'b0;

    // Interrupt levels per threshold code
    localparam logic [4:0] THR_LVL0 = 5'h01;
    localparam logic [4:0] THR_LVL1 = 5'h04;
    localparam logic [4:0] THR_LVL2 = 5'h08;
    localparam logic [4:0] THR_LVL3 = 5'h0E;

    // Timebase divide ratios of the main clock, per code
    localparam logic [6:0] DIV_RATIO0 = 7'h08;
    localparam logic [6:0] DIV_RATIO1 = 7'h10;
    localparam logic [6:0] DIV_RATIO2 = 7'h20;
    localparam logic [6:0] DIV_RATIO3 = 7'h40;
endpackage : pbd_pkg

// file: pbd_tick_timer.sv
module pbd_tick_timer
    import pbd_pkg::*;
#(
    parameter int TICK_W = PBD_TICK_W
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Control
    input wire logic stop_in,
    input wire logic run_in,
    input wire logic [1:0] div_code_in,
    input wire logic clear_in,
    input wire logic load_in,
    input wire logic [TICK_W-1:0] load_value_in,
    // State
    output logic advance_out,
    output logic [TICK_W-1:0] value_out
);
    logic [6:0] div_cnt;
    logic [6:0] ratio;

    always_comb begin
        case (div_code_in)
            2'h0: ratio = DIV_RATIO0;
            2'h1: ratio = DIV_RATIO1;
            2'h2: ratio = DIV_RATIO2;
            default: ratio = DIV_RATIO3;
        endcase
    end

    // Prescaler stands still while the block is off or the timer halted
    always_ff @(posedge clk_in) begin
        if (rst_in || stop_in || !run_in || clear_in || load_in) begin
            div_cnt <= 7'h00;
            advance_out <= 1'b0;
        end else if (div_cnt >= ratio - 7'h01) begin
            div_cnt <= 7'h00;
            advance_out <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 7'h01;
            advance_out <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || stop_in || clear_in) begin
            value_out <= '0;
        end else if (load_in) begin
            value_out <= load_value_in;
        end else if (run_in && div_cnt >= ratio - 7'h01) begin
            value_out <= value_out + 1'b1;
        end
    end
endmodule : pbd_tick_timer

// file: pbd_capture_queue.sv
module pbd_capture_queue
    import pbd_pkg::*;
#(
    parameter int DATA_W = PBD_DATA_W,
    parameter int DEPTH = PBD_DEPTH,
    parameter int CNT_W = PBD_CNT_W
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Control
    input wire logic flush_in,
    input wire logic push_in,
    input wire logic [DATA_W-1:0] push_data_in,
    input wire logic pop_in,
    // State
    output logic [DATA_W-1:0] head_out,
    output logic [CNT_W-1:0] count_out
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);

    logic [DATA_W-1:0] mem [DEPTH];
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W-1:0] wr_ptr;
    logic full;
    logic remove;

    assign full = (count_out == FULL_CNT);
    // A push into a full queue drops the oldest entry unless a read does
    assign remove = (pop_in && count_out != '0) || (push_in && full);
    assign head_out = mem[rd_ptr];

    always_ff @(posedge clk_in) begin
        if (push_in) begin
            mem[wr_ptr] <= push_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in || flush_in) begin
            rd_ptr <= '0;
            wr_ptr <= '0;
            count_out <= '0;
        end else begin
            if (push_in) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (remove) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push_in && !remove) begin
                count_out <= count_out + 1'b1;
            end else if (!push_in && remove) begin
                count_out <= count_out - 1'b1;
            end
        end
    end
endmodule : pbd_capture_queue

// file: pbd_post_code_queue.sv
// Functional notes
// - Sixteen 32-bit queue entries and a 24-bit timestamp that counts only while the run bit is set.
// - Host only writes codes; controller reads and controls via own registers.
// - Each host byte write while active pushes byte joined with current timestamp.
// - Host data register reads return zero and leave queue untouched.
// - Write into full queue drops oldest entry and sets overflow flag, unless a controller read takes that entry in the same cycle.
// - Controller data word: timestamp in 31:8, host byte in 7:0.
// - Interrupt asserts while queued count reaches programmed threshold.
// - Interrupt driven with no local mask whenever block is active.
// - Threshold codes 0..3 give levels 1, 4, 8 and 14.
// - Inactive: no host claims, queue empty, timer cleared and halted.
// - Activation leaves configuration settings unchanged.
// - Timer advances only while run bit is set, else holds.
// - Timebase codes 0..3 divide main clock by 8, 16, 32, 64.
// - Writing 1 to clear bit zeroes timer; bit reads zero.
// - Writing zero to count register clears the timer too.
// - Count register writes load timer; reads return present value.
// - Writing 1 to flush bit empties queue; bit reads zero.
// - Not-empty status bit shows whether queue holds an entry.
module pbd_post_code_queue
    import pbd_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Host data port
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    input wire logic [7:0] host_wdata_in,
    output logic host_claim_out,
    output logic [7:0] host_rdata_out,
    // Controller register port
    input wire logic [PBD_ADDR_W-1:0] ec_addr_in,
    input wire logic ec_wr_in,
    input wire logic ec_rd_in,
    input wire logic [PBD_DATA_W-1:0] ec_wdata_in,
    output logic [PBD_DATA_W-1:0] ec_rdata_out,
    output logic ec_rvalid_out,
    // Interrupt
    output logic post_code_irq_out
);
    logic active;
    logic [1:0] thr_code;
    logic timer_run;
    logic [1:0] tick_divider_code;
    logic overflow;

    logic wr_cfg;
    logic wr_cnt;
    logic wr_act;
    logic rd_queue;
    logic push;
    logic flush;
    logic tick_clear;
    logic tick_advance;
    logic queue_full;
    logic [4:0] thr_level;
    logic [PBD_TICK_W-1:0] captured_tick_value;
    logic [PBD_DATA_W-1:0] head;
    logic [PBD_CNT_W-1:0] count;
    logic [PBD_DATA_W-1:0] next_rdata;

    // Address decode
    assign wr_cfg = ec_wr_in && (ec_addr_in == OFF_CONFIG);
    assign wr_cnt = ec_wr_in && (ec_addr_in == OFF_COUNT);
    assign wr_act = ec_wr_in && (ec_addr_in == OFF_ACTIVATE);
    assign rd_queue = ec_rd_in && (ec_addr_in == OFF_QUEUE_READ);

    assign push = host_wr_in && active;
    assign flush = !active || (wr_cfg && ec_wdata_in[CFG_FLUSH_BIT]);
    assign tick_clear = (wr_cfg && ec_wdata_in[CFG_CLR_BIT])
        || (wr_cnt && ec_wdata_in[PBD_DATA_W-1:CODE_W] == '0);
    assign queue_full = (count == PBD_CNT_W'(PBD_DEPTH));

    always_comb begin
        case (thr_code)
            2'h0: thr_level = THR_LVL0;
            2'h1: thr_level = THR_LVL1;
            2'h2: thr_level = THR_LVL2;
            default: thr_level = THR_LVL3;
        endcase
    end

    pbd_capture_queue #(
        .DATA_W(PBD_DATA_W),
        .DEPTH(PBD_DEPTH),
        .CNT_W(PBD_CNT_W)
    ) u_queue (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .flush_in(flush),
        .push_in(push),
        .push_data_in({captured_tick_value, host_wdata_in}),
        .pop_in(rd_queue),
        .head_out(head),
        .count_out(count)
    );

    pbd_tick_timer #(
        .TICK_W(PBD_TICK_W)
    ) u_timer (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .stop_in(!active),
        .run_in(timer_run),
        .div_code_in(tick_divider_code),
        .clear_in(tick_clear),
        .load_in(wr_cnt),
        .load_value_in(ec_wdata_in[PBD_DATA_W-1:CODE_W]),
        .advance_out(tick_advance),
        .value_out(captured_tick_value)
    );

    // Activation bit
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            active <= ACT_RESET;
        end else if (wr_act) begin
            active <= ec_wdata_in[ACT_BIT];
        end
    end

    // Configuration fields are untouched by activation
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            thr_code <= THR_RESET;
            timer_run <= RUN_RESET;
            tick_divider_code <= TB_RESET;
        end else if (wr_cfg) begin
            thr_code <= ec_wdata_in[CFG_THR_LSB+:2];
            timer_run <= ec_wdata_in[CFG_RUN_BIT];
            tick_divider_code <= ec_wdata_in[CFG_TB_LSB+:2];
        end
    end

    // Overflow flag: a new overflow wins over a flush in the same cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            overflow <= 1'b0;
        end else if (push && queue_full && !rd_queue) begin
            overflow <= 1'b1;
        end else if (flush) begin
            overflow <= 1'b0;
        end
    end

    // Host answers: reads always zero, claims only while active
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            host_claim_out <= 1'b0;
            host_rdata_out <= 8'h00;
        end else begin
            host_claim_out <= (host_wr_in || host_rd_in) && active;
            host_rdata_out <= 8'h00;
        end
    end

    // Controller read mux
    always_comb begin
        next_rdata = '0;
        case (ec_addr_in)
            OFF_QUEUE_READ: begin
                if (count != '0) begin
                    next_rdata = head;
                end
            end
            OFF_CONFIG: begin
                next_rdata[CFG_THR_LSB+:2] = thr_code;
                next_rdata[CFG_RUN_BIT] = timer_run;
                next_rdata[CFG_TB_LSB+:2] = tick_divider_code;
            end
            OFF_STATUS: begin
                next_rdata[ST_OVR_BIT] = overflow;
                next_rdata[ST_NE_BIT] = (count != '0);
            end
            OFF_COUNT: begin
                next_rdata[PBD_DATA_W-1:CODE_W] = captured_tick_value;
            end
            OFF_ACTIVATE: begin
                next_rdata[ACT_BIT] = active;
            end
            default: begin
                next_rdata = '0;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ec_rdata_out <= '0;
            ec_rvalid_out <= 1'b0;
        end else begin
            ec_rvalid_out <= ec_rd_in;
            if (ec_rd_in) begin
                ec_rdata_out <= next_rdata;
            end
        end
    end

    // Interrupt level, unmasked while active
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            post_code_irq_out <= 1'b0;
        end else begin
            post_code_irq_out <= active && (count >= thr_level);
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_plain_push;
        push && !queue_full && !rd_queue && !flush;
    endsequence

    sequence s_pop_taken;
        rd_queue && count != '0 && !push && !flush;
    endsequence

    sequence s_overflow_push;
        push && queue_full && !rd_queue && !flush;
    endsequence

    a_push_counts: assert property (
        s_plain_push |=> count == $past(count) + 1'b1)
        else $error("host write did not add one entry");

    a_host_read_zero: assert property (
        host_rd_in && !push && !rd_queue && !flush
        |=> host_rdata_out == 8'h00 && $stable(count))
        else $error("host read disturbed queue or returned data");

    a_overflow_drop: assert property (
        s_overflow_push |=> overflow && queue_full)
        else $error("overflow write lost count or flag");

    a_read_layout: assert property (
        s_pop_taken
        |=> ec_rvalid_out && ec_rdata_out == $past(head))
        else $error("controller read returned wrong word");

    a_pop_shrinks: assert property (
        s_pop_taken |=> count == $past(count) - 1'b1)
        else $error("controller read did not remove entry");

    a_irq_level: assert property (
        active && count >= thr_level && !flush && !rd_queue
        |=> post_code_irq_out)
        else $error("interrupt missing at threshold");

    a_irq_inactive: assert property (
        !active |=> ##1 !post_code_irq_out)
        else $error("interrupt while inactive");

    a_inactive_state: assert property (
        !active |=> count == '0 && captured_tick_value == '0)
        else $error("inactive block kept queue or timer");

    a_cfg_kept: assert property (
        wr_act && !wr_cfg |=> $stable(thr_code) && $stable(timer_run)
            && $stable(tick_divider_code))
        else $error("activation changed configuration");

    a_timer_hold: assert property (
        active && !timer_run && !tick_clear && !wr_cnt && !wr_act
        |=> $stable(captured_tick_value))
        else $error("timer moved while halted");

    a_tick_spacing: assert property (
        tick_advance && tick_divider_code == 2'h0 && timer_run
            && !wr_cfg && !wr_cnt && !wr_act
        |=> !tick_advance [*7])
        else $error("timebase advanced faster than divide by eight");

    a_clear_bit: assert property (
        active && wr_cfg && ec_wdata_in[CFG_CLR_BIT] && !wr_act
        |=> captured_tick_value == '0)
        else $error("timestamp clear bit did not zero timer");

    a_count_load: assert property (
        active && wr_cnt |=> captured_tick_value
            == $past(ec_wdata_in[PBD_DATA_W-1:CODE_W]))
        else $error("count write did not load timer");

    a_flush_empty: assert property (
        wr_cfg && ec_wdata_in[CFG_FLUSH_BIT] |=> count == '0)
        else $error("flush left entries behind");

    // The advance pulse comes in the same cycle as the increment
    a_tick_wrap: assert property (
        tick_advance && $past(captured_tick_value) == '1
        |-> captured_tick_value == '0)
        else $error("timer did not wrap to zero");

    sequence s_zero_count_write;
        active && wr_cnt && ec_wdata_in[PBD_DATA_W-1:CODE_W] == '0;
    endsequence

    a_zero_write_clear: assert property (
        s_zero_count_write |=> captured_tick_value == '0)
        else $error("zero count write did not clear timer");

    a_irq_below: assert property (
        count < thr_level |=> !post_code_irq_out)
        else $error("interrupt below threshold");

    a_level_top: assert property (
        active && thr_code == 2'h3 && count == 5'h0D
        |=> !post_code_irq_out)
        else $error("top threshold fired below fourteen entries");

    a_claim_gate: assert property (
        !active |=> !host_claim_out)
        else $error("host access claimed while inactive");

    a_claim_push: assert property (
        push |=> host_claim_out)
        else $error("host write not claimed");

    a_rvalid_on: assert property (
        ec_rd_in |=> ec_rvalid_out)
        else $error("read valid missing after read");

    a_rvalid_off: assert property (
        !ec_rd_in |=> !ec_rvalid_out)
        else $error("read valid without read");

    a_status_flag: assert property (
        ec_rd_in && ec_addr_in == OFF_STATUS
        |=> ec_rdata_out[ST_NE_BIT] == ($past(count) != '0))
        else $error("not-empty status wrong");

    a_unmapped_zero: assert property (
        ec_rd_in && ec_addr_in != OFF_QUEUE_READ && ec_addr_in != OFF_CONFIG
            && ec_addr_in != OFF_STATUS && ec_addr_in != OFF_COUNT
            && ec_addr_in != OFF_ACTIVATE
        |=> ec_rdata_out == '0)
        else $error("unmapped read returned data");

    a_cfg_wo_bits: assert property (
        ec_rd_in && ec_addr_in == OFF_CONFIG
        |=> ec_rdata_out[CFG_FLUSH_BIT+:2] == 2'h0)
        else $error("clear or flush bit read back as one");
endmodule : pbd_post_code_queue

// file: pbd_host_model.sv
module pbd_host_model (
    // Clock
    input wire logic clk_in,
    // Host bus
    output logic host_wr_out,
    output logic host_rd_out,
    output logic [7:0] host_wdata_out
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        host_wr_out = 1'b0;
        host_rd_out = 1'b0;
        host_wdata_out = 8'hA5;
    end

    // One strobe cycle per access; released data shows the inverse
    task automatic host_cycle(input logic wr, input logic [7:0] b);
        @(negedge clk_in);
        host_wr_out = wr;
        host_rd_out = !wr;
        host_wdata_out = b;
        @(negedge clk_in);
        host_wr_out = 1'b0;
        host_rd_out = 1'b0;
        host_wdata_out = ~b;
    endtask : host_cycle

    task automatic put_code(input logic [7:0] b);
        host_cycle(1'b1, b);
    endtask : put_code

    task automatic get_code;
        host_cycle(1'b0, host_wdata_out);
    endtask : get_code
endmodule : pbd_host_model

// file: bios_post_code_fifo_tb.sv
module bios_post_code_fifo_tb
    import pbd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic host_wr_in, host_rd_in, host_claim_out, ec_wr_in, ec_rd_in;
    logic ec_rvalid_out, post_code_irq_out;
    logic [7:0] host_wdata_in, host_rdata_out;
    logic [11:0] ec_addr_in = 12'h000;
    logic [31:0] ec_wdata_in = 32'h0, ec_rdata_out;
    int n_mismatch = 0;
    int tests_run = 0;

    always #50 clk_in = ~clk_in;

    initial begin
        ec_wr_in = 1'b0;
        ec_rd_in = 1'b0;
    end

    pbd_host_model pbd_host_model_i (.clk_in(clk_in),
        .host_wr_out(host_wr_in), .host_rd_out(host_rd_in),
        .host_wdata_out(host_wdata_in));

    pbd_post_code_queue pbd_post_code_queue_i (.clk_in(clk_in),
        .rst_in(rst_in), .host_wr_in(host_wr_in), .host_rd_in(host_rd_in),
        .host_wdata_in(host_wdata_in), .host_claim_out(host_claim_out),
        .host_rdata_out(host_rdata_out), .ec_addr_in(ec_addr_in),
        .ec_wr_in(ec_wr_in), .ec_rd_in(ec_rd_in),
        .ec_wdata_in(ec_wdata_in), .ec_rdata_out(ec_rdata_out),
        .ec_rvalid_out(ec_rvalid_out),
        .post_code_irq_out(post_code_irq_out));

    task automatic final_report;
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // One strobe cycle per request; wr picks write or read
    task automatic ec_req(input logic wr, input logic [11:0] a,
                          input logic [31:0] d);
        @(negedge clk_in);
        ec_addr_in = a;
        ec_wdata_in = d;
        ec_wr_in = wr;
        ec_rd_in = !wr;
        @(negedge clk_in);
        ec_wr_in = 1'b0;
        ec_rd_in = 1'b0;
    endtask : ec_req

    task automatic ecw(input logic [11:0] a, input logic [31:0] d);
        ec_req(1'b1, a, d);
    endtask : ecw

    // Data counts only when the valid pulse came with it
    task automatic ecr(input logic [11:0] a, output logic [31:0] d);
        ec_req(1'b0, a, ec_wdata_in);
        d = (ec_rvalid_out === 1'b1) ? ec_rdata_out : 32'hDEADBEEF;
    endtask : ecr

    task automatic ecc(input string n, input logic [11:0] a,
                       input logic [31:0] e);
        logic [31:0] d;
        ecr(a, d);
        chk(n, e, d);
    endtask : ecc

    task automatic t_reset;
        ecc("config", OFF_CONFIG, 32'h0);
        ecc("count", OFF_COUNT, 32'h0);
        ecc("activate", OFF_ACTIVATE, 32'h0);
        ecc("unmapped", 12'h200, 32'h0);
        pbd_host_model_i.put_code(8'h11);
        chk("claim_off", 32'h0, {31'h0, host_claim_out});
        ecc("status_off", OFF_STATUS, 32'h0);
    endtask : t_reset

    task automatic t_capture;
        ecw(OFF_ACTIVATE, 32'h1);
        ecw(OFF_COUNT, 32'h12345600);
        ecc("count_held", OFF_COUNT, 32'h12345600);
        pbd_host_model_i.put_code(8'h5A);
        chk("claim", 32'h1, {31'h0, host_claim_out});
        pbd_host_model_i.get_code;
        chk("host_rdata", 32'h0, {24'h0, host_rdata_out});
        ecc("status_ne", OFF_STATUS, 32'h1);
        ecc("entry", OFF_QUEUE_READ, 32'h1234565A);
        ecc("status_mt", OFF_STATUS, 32'h0);
    endtask : t_capture

    task automatic t_timer;
        logic [31:0] v;
        for (int d = 0; d < 4; d++) begin
            ecw(OFF_CONFIG, {26'h0, 1'b1, d[1:0], 3'h0});
            ecw(OFF_COUNT, 32'h0);
            repeat (10 << (d + 3)) @(negedge clk_in);
            ecr(OFF_COUNT, v);
            chk("tick", 32'h00000A00, v);
        end
        ecw(OFF_CONFIG, 32'h24);
        ecr(OFF_COUNT, v);
        chk("clear", 32'h0, {8'h0, v[31:8]});
        ecw(OFF_CONFIG, 32'hFE);
        ecc("cfg_rd", OFF_CONFIG, 32'hF8);
        ecw(12'h204, 32'hFFFFFFFF);
        ecc("cfg_kept", OFF_CONFIG, 32'hF8);
        ecw(OFF_CONFIG, 32'h20);
        ecw(OFF_COUNT, 32'hFFFFFF00);
        repeat (24) @(negedge clk_in);
        ecr(OFF_COUNT, v);
        chk("wrap", 32'h00000200, v);
        ecw(OFF_CONFIG, 32'h0);
        ecw(OFF_COUNT, 32'h00007700);
        repeat (100) @(negedge clk_in);
        ecc("stopped", OFF_COUNT, 32'h00007700);
    endtask : t_timer

    task automatic t_overflow;
        for (int i = 0; i < 17; i++) begin
            pbd_host_model_i.put_code(i[7:0]);
        end
        ecc("overflow", OFF_STATUS, 32'h3);
        for (int i = 1; i < 17; i++) begin
            ecc("order", OFF_QUEUE_READ, {24'h000077, i[7:0]});
        end
        ecc("drained", OFF_STATUS, 32'h2);
        ecc("empty_rd", OFF_QUEUE_READ, 32'h0);
        ecw(OFF_CONFIG, 32'h2);
        ecc("flushed", OFF_STATUS, 32'h0);
    endtask : t_overflow

    task automatic t_irq;
        int lvl[4] = '{1, 4, 8, 14};
        for (int c = 0; c < 4; c++) begin
            ecw(OFF_CONFIG, {24'h0, c[1:0], 6'h0});
            for (int k = 0; k < lvl[c] - 1; k++) begin
                pbd_host_model_i.put_code(8'hC0);
            end
            @(negedge clk_in);
            chk("irq_low", 32'h0, {31'h0, post_code_irq_out});
            pbd_host_model_i.put_code(8'hC1);
            @(negedge clk_in);
            chk("irq_high", 32'h1, {31'h0, post_code_irq_out});
            ecw(OFF_CONFIG, {24'h0, c[1:0], 6'h2});
            @(negedge clk_in);
            chk("irq_flush", 32'h0, {31'h0, post_code_irq_out});
        end
    endtask : t_irq

    task automatic t_deact;
        ecw(OFF_CONFIG, 32'h28);
        repeat (3) pbd_host_model_i.put_code(8'h3C);
        @(negedge clk_in);
        chk("irq_on", 32'h1, {31'h0, post_code_irq_out});
        ecw(OFF_ACTIVATE, 32'h0);
        ecc("deact_st", OFF_STATUS, 32'h0);
        chk("irq_off", 32'h0, {31'h0, post_code_irq_out});
        ecc("deact_cnt", OFF_COUNT, 32'h0);
        ecc("deact_cfg", OFF_CONFIG, 32'h28);
        pbd_host_model_i.put_code(8'h3D);
        chk("deact_claim", 32'h0, {31'h0, host_claim_out});
        ecc("deact_q", OFF_STATUS, 32'h0);
        ecw(OFF_ACTIVATE, 32'h1);
        ecc("react_cfg", OFF_CONFIG, 32'h28);
    endtask : t_deact

    initial begin
        repeat (4) @(negedge clk_in);
        rst_in = 1'b0;
        t_reset;
        t_capture;
        t_timer;
        t_overflow;
        t_irq;
        t_deact;
        final_report;
    end

    initial begin
        #2000000;
        n_mismatch++;
        final_report;
    end
endmodule : bios_post_code_fifo_tb
